// File: design/cel_pkg.sv
// Purpose: Shared constants and types of the comparator event logic
// Assumes: 32-bit AXI4-Lite register port, one bus clock
// Notes: Register layout and reset values live here only
`default_nettype none
package cel_pkg;
  // ****************************************
  // Bus and register map
  // ****************************************
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] MASK_OFFSET = 12'h008;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // Field positions and widths
  // ****************************************
  localparam int unsigned CTRL_W = 5;
  localparam int unsigned EVT_W = 1;
  localparam int unsigned FLAG_BIT = 0;
  localparam int unsigned LEVEL_BIT = 1;
  localparam int unsigned IE_BIT = 0;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    CEL_EDGE_FALL = 2'h0,
    CEL_EDGE_RISE = 2'h1,
    CEL_EDGE_BOTH = 2'h3
  } cel_edge_t;
  typedef enum logic [2:0] {
    CEL_PWR_RUN = 3'h0,
    CEL_PWR_WAIT = 3'h1,
    CEL_PWR_SHALLOW = 3'h3,
    CEL_PWR_DEEP_A = 3'h2,
    CEL_PWR_DEEP_B = 3'h6
  } cel_power_t;
  // Bits 4:3 edge, 2 pin enable, 1 bandgap, 0 enable
  typedef struct packed {
    cel_edge_t edge_sel;
    logic output_pin_en;
    logic bandgap_sel;
    logic enable;
  } cel_ctrl_t;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
  localparam logic [EVT_W-1:0] MASK_RESET = 1'h0;
  localparam logic [EVT_W-1:0] STATUS_RESET = 1'h0;
endpackage
`default_nettype wire

// File: design/cel_sync_edge.sv
// Purpose: Brings the comparator output into the bus clock, finds edges
// Assumes: async_in is asynchronous to aclk
// Notes: A change counts once the second and third stages agree
`default_nettype none
module cel_sync_edge (
  input wire logic aclk,
  input wire logic rst_n,
  input wire logic async_in,
  input wire logic enable,
  input wire cel_pkg::cel_edge_t edge_sel,
  output logic level,
  output logic evt_pulse
);
  logic s1;
  logic s2;
  logic s3;
  logic qualify;

  // ****************************************
  // Three-stage synchroniser
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_comb begin
    qualify = 1'b0;
    unique case (edge_sel)
      cel_pkg::CEL_EDGE_RISE: qualify = s3;
      cel_pkg::CEL_EDGE_FALL: qualify = !s3;
      default: qualify = 1'b1;
    endcase
  end

  // ****************************************
  // Agreed level and single event pulse
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      level <= 1'b0;
      evt_pulse <= 1'b0;
    end else begin
      evt_pulse <= 1'b0;
      if (s2 == s3 && s3 != level) begin // [RULE_10]
        level <= s3;
        evt_pulse <= enable && qualify; // [RULE_01]
      end
    end
  end

  level_agree_a: assert property (@(posedge aclk) disable iff (!rst_n) // [RULE_10]
    $changed(level) |-> $past(s2) == $past(s3) && level == $past(s3))
    else $error("level changed without agreeing stages");
endmodule
`default_nettype wire

// File: design/cel_irq.sv
// Purpose: Sticky event status, mask and one level interrupt
// Assumes: clr is a write-one-to-clear strobe
// Notes: A set in the clearing cycle wins
`default_nettype none
module cel_irq #(
  parameter int unsigned W = 1
) (
  input wire logic aclk,
  input wire logic rst_n,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  input wire logic [W-1:0] mask,
  output logic [W-1:0] status,
  output logic irq
);
  // ****************************************
  // Sticky bits
  // ****************************************
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge aclk) begin
      if (!rst_n) begin
        status[i] <= 1'b0;
      end else if (set[i]) begin
        status[i] <= 1'b1;
      end else if (clr[i]) begin
        status[i] <= 1'b0;
      end
    end
  end

  assign irq = |(status & mask);

  set_wins_a: assert property (@(posedge aclk) disable iff (!rst_n)
    set[0] && clr[0] |=> status[0])
    else $error("event lost against clear");
endmodule
`default_nettype wire

// File: design/cel_top.sv
// Purpose: Control and event logic around an analog comparator
// Assumes: power_mode and debug_active come from logic on aclk
// Notes: Deep stop modes hold the block in reset
//
// How it works
// [RULE_01] Software picks rising, falling or both edges for the event flag.
// [RULE_02] A control bit swaps one comparator input for the bandgap reference.
// [RULE_03] A control bit drives the comparator result onto its output pin.
// [RULE_04] In wait the enabled comparator runs; an enabled event wakes the core.
// [RULE_05] In shallow stop comparing and pin output continue as in run.
// [RULE_06] In shallow stop a selected edge sets the flag and may wake.
// [RULE_07] Reset out of shallow stop returns all state to reset values.
// [RULE_08] Deep stop modes power the comparator down and reset its state.
// [RULE_09] Background debug halt does not change comparator behaviour.
// [RULE_10] Comparator output is synchronised so each edge flags once.
`default_nettype none
module cel_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [cel_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [cel_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cel_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [cel_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic comparator_raw,
  output logic comparator_power_en,
  output logic bandgap_select,
  output logic comparator_result_pin,
  output logic comparator_result_pin_en,
  input wire cel_pkg::cel_power_t power_mode,
  input wire logic debug_active,
  output logic irq,
  output logic cpu_wake
);
  logic deep_stop;
  logic blk_rst_n;
  logic aw_held;
  logic w_held;
  logic [cel_pkg::ADDR_W-1:0] aw_addr;
  logic [cel_pkg::DATA_W-1:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;
  logic wr_mapped;
  cel_pkg::cel_ctrl_t ctrl;
  logic [cel_pkg::EVT_W-1:0] comparator_interrupt_enable;
  logic [cel_pkg::EVT_W-1:0] status;
  logic [cel_pkg::EVT_W-1:0] status_clr;
  logic cmp_level;
  logic evt_pulse;
  logic rd_mapped;
  logic [cel_pkg::DATA_W-1:0] rd_word;
  logic cfg_en;
  logic cfg_pin;
  cel_pkg::cel_edge_t cfg_edge;

  // ****************************************
  // Power mode
  // ****************************************
  assign deep_stop = power_mode == cel_pkg::CEL_PWR_DEEP_A
    || power_mode == cel_pkg::CEL_PWR_DEEP_B;
  // Debug halt is deliberately not a term here
  assign blk_rst_n = aresetn && !deep_stop; // [RULE_07] [RULE_08] [RULE_09]
  assign cfg_en = ctrl.enable;
  assign cfg_pin = ctrl.output_pin_en;
  assign cfg_edge = ctrl.edge_sel;

  // ****************************************
  // AXI4-Lite write channels
  // ****************************************
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_ctrl = do_write && aw_addr == cel_pkg::CTRL_OFFSET;
  assign wr_status = do_write && aw_addr == cel_pkg::STATUS_OFFSET;
  assign wr_mask = do_write && aw_addr == cel_pkg::MASK_OFFSET;
  assign wr_mapped = wr_ctrl || wr_status || wr_mask;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && !aw_held) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && !w_held) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cel_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? cel_pkg::RESP_OKAY : cel_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // Control and mask registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!blk_rst_n) begin
      ctrl <= cel_pkg::cel_ctrl_t'(cel_pkg::CTRL_RESET); // [RULE_07] [RULE_08]
    end else if (wr_ctrl && w_strb[0]) begin
      ctrl <= cel_pkg::cel_ctrl_t'(w_data[cel_pkg::CTRL_W-1:0]); // [RULE_01]
    end
  end

  always_ff @(posedge aclk) begin
    if (!blk_rst_n) begin
      comparator_interrupt_enable <= cel_pkg::MASK_RESET;
    end else if (wr_mask && w_strb[0]) begin
      comparator_interrupt_enable <= w_data[cel_pkg::IE_BIT +: cel_pkg::EVT_W];
    end
  end

  assign status_clr = (wr_status && w_strb[0])
    ? w_data[cel_pkg::FLAG_BIT +: cel_pkg::EVT_W] : cel_pkg::STATUS_RESET;

  // ****************************************
  // Edge detection and event flag
  // ****************************************
  cel_sync_edge u_sync (
    .aclk(aclk),
    .rst_n(blk_rst_n),
    .async_in(comparator_raw),
    .enable(cfg_en),
    .edge_sel(cfg_edge),
    .level(cmp_level),
    .evt_pulse(evt_pulse)
  );

  cel_irq #(
    .W(cel_pkg::EVT_W)
  ) u_irq (
    .aclk(aclk),
    .rst_n(blk_rst_n),
    .set(evt_pulse),
    .clr(status_clr),
    .mask(comparator_interrupt_enable),
    .status(status),
    .irq(irq)
  );

  // Wake only where the core can be asleep with the bus clock running
  assign cpu_wake = irq && (power_mode == cel_pkg::CEL_PWR_WAIT
    || power_mode == cel_pkg::CEL_PWR_SHALLOW); // [RULE_04] [RULE_06]

  // ****************************************
  // Analog controls and result pin
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!blk_rst_n) begin
      comparator_power_en <= 1'b0; // [RULE_08]
      bandgap_select <= 1'b0;
      comparator_result_pin_en <= 1'b0;
      comparator_result_pin <= 1'b0;
    end else begin
      comparator_power_en <= cfg_en;
      bandgap_select <= ctrl.bandgap_sel; // [RULE_02]
      comparator_result_pin_en <= cfg_en && cfg_pin; // [RULE_03] [RULE_05]
      comparator_result_pin <= cfg_en && cfg_pin && cmp_level; // [RULE_03]
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  always_comb begin
    rd_word = '0;
    rd_mapped = 1'b1;
    unique case (s_axi_araddr)
      cel_pkg::CTRL_OFFSET: rd_word[cel_pkg::CTRL_W-1:0] = ctrl;
      cel_pkg::STATUS_OFFSET: begin
        rd_word[cel_pkg::FLAG_BIT] = status[0];
        rd_word[cel_pkg::LEVEL_BIT] = cmp_level;
      end
      cel_pkg::MASK_OFFSET: rd_word[cel_pkg::IE_BIT] = comparator_interrupt_enable[0];
      default: rd_mapped = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= cel_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_mapped ? cel_pkg::RESP_OKAY : cel_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!blk_rst_n);

  sequence evt_in_stop;
    power_mode == cel_pkg::CEL_PWR_SHALLOW && evt_pulse;
  endsequence

  sequence pin_on_in_stop;
    power_mode == cel_pkg::CEL_PWR_SHALLOW && cfg_en && cfg_pin;
  endsequence

  edge_rise_a: assert property ( // [RULE_01]
    $rose(cmp_level) && $past(cfg_en) && $past(cfg_edge) == cel_pkg::CEL_EDGE_RISE
    |-> evt_pulse)
    else $error("rising edge missed");

  edge_fall_a: assert property ( // [RULE_01]
    $rose(cmp_level) && $past(cfg_edge) == cel_pkg::CEL_EDGE_FALL |-> !evt_pulse)
    else $error("rising edge flagged in falling mode");

  bandgap_out_a: assert property ( // [RULE_02]
    ctrl.bandgap_sel ##1 ctrl.bandgap_sel |-> bandgap_select)
    else $error("bandgap select not driven");

  pin_follow_a: assert property ( // [RULE_03]
    cfg_en && cfg_pin ##1 cfg_en && cfg_pin
    |-> comparator_result_pin_en && comparator_result_pin == $past(cmp_level))
    else $error("result pin does not follow comparator");

  wait_wake_a: assert property ( // [RULE_04]
    power_mode == cel_pkg::CEL_PWR_WAIT && status[0] && comparator_interrupt_enable[0]
    |-> cpu_wake)
    else $error("no wake from wait");

  stop_pin_a: assert property ( // [RULE_05]
    pin_on_in_stop ##1 pin_on_in_stop |-> comparator_result_pin == $past(cmp_level))
    else $error("pin stalled in shallow stop");

  stop_flag_a: assert property ( // [RULE_06]
    evt_in_stop ##1 (power_mode == cel_pkg::CEL_PWR_SHALLOW
      && comparator_interrupt_enable[0]) |-> status[0] && cpu_wake)
    else $error("shallow stop event did not flag and wake");

  reset_clear_a: assert property (disable iff (1'b0) // [RULE_07]
    !aresetn |=> ctrl == cel_pkg::CTRL_RESET && status == cel_pkg::STATUS_RESET
      && comparator_interrupt_enable == cel_pkg::MASK_RESET)
    else $error("state not reset");

  deep_off_a: assert property (disable iff (!aresetn) // [RULE_08]
    deep_stop |=> !comparator_power_en && ctrl == cel_pkg::CTRL_RESET
      && status == cel_pkg::STATUS_RESET)
    else $error("deep stop did not power down");

  debug_same_a: assert property ( // [RULE_09]
    debug_active && evt_pulse |=> status[0])
    else $error("event lost in debug halt");

  once_only_a: assert property ( // [RULE_10]
    evt_pulse |=> !evt_pulse)
    else $error("one transition flagged twice");

  clear_flag_a: assert property ( // [RULE_01]
    status_clr[0] && !evt_pulse |=> !status[0])
    else $error("flag not cleared by write");

  result_off_a: assert property ( // [RULE_03]
    !cfg_en || !cfg_pin |=> !comparator_result_pin_en && !comparator_result_pin)
    else $error("result pin driven while off");

  deep_pin_a: assert property (disable iff (!aresetn) // [RULE_08]
    deep_stop |=> !comparator_result_pin_en && !bandgap_select && !irq)
    else $error("deep stop left outputs on");
endmodule
`default_nettype wire

// File: verif/cel_top_bench.sv
// Purpose: Self-checking bench for the comparator event logic
// Assumes: AXI4-Lite master driven here, comparator output driven here
// Notes: Edge cases run from a table, power modes by hand
`default_nettype none
module cel_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [4:0] ctrl;
    logic from_lvl;
    logic to_lvl;
    logic flag;
  } cel_row_t;
  localparam logic [11:0] A_CTRL = cel_pkg::CTRL_OFFSET;
  localparam logic [11:0] A_STAT = cel_pkg::STATUS_OFFSET;
  localparam logic [11:0] A_MASK = cel_pkg::MASK_OFFSET;
  localparam logic [1:0] OK = cel_pkg::RESP_OKAY;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, raw, pwr_en, bg_sel, res_pin, res_pin_en;
  logic dbg, irq, wake;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  cel_pkg::cel_power_t pmode;
  int n_mismatch = 0;
  int n_checks = 0;
  cel_row_t rows[8] = '{
    '{5'h01, 1'b1, 1'b0, 1'b1}, '{5'h01, 1'b0, 1'b1, 1'b0},
    '{5'h09, 1'b0, 1'b1, 1'b1}, '{5'h09, 1'b1, 1'b0, 1'b0},
    '{5'h19, 1'b0, 1'b1, 1'b1}, '{5'h19, 1'b1, 1'b0, 1'b1},
    '{5'h11, 1'b1, 1'b0, 1'b1}, '{5'h08, 1'b1, 1'b0, 1'b0}};

  cel_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .comparator_raw(raw), .comparator_power_en(pwr_en),
    .bandgap_select(bg_sel), .comparator_result_pin(res_pin),
    .comparator_result_pin_en(res_pin_en), .power_mode(pmode),
    .debug_active(dbg), .irq(irq), .cpu_wake(wake));

  // ******************************
  // Helpers
  // ******************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic chk1(input logic seen, input logic exp, input string msg);
    chk({31'h0, seen}, {31'h0, exp}, msg);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        got = 1'b1;
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er}, "write response");
      end
    end
  endtask
  task automatic rdr(input logic [11:0] a);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        got = 1'b1;
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
      end
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string msg);
    rdr(a);
    chk(rd, e, msg);
    chk({30'h0, rs}, {30'h0, OK}, msg);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ******************************
  // Clock, watchdog and tests
  // ******************************
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, raw, dbg} = 8'h00;
    {awaddr, araddr, wdata} = 56'h0;
    wstrb = 4'hF;
    pmode = cel_pkg::CEL_PWR_RUN;
    cyc(6);
    aresetn <= 1'b1;
    rchk(A_CTRL, 32'h0, "ctrl reset");
    rchk(A_MASK, 32'h0, "mask reset");
    wr(12'h00C, 32'h1F, cel_pkg::RESP_SLVERR);
    rdr(12'h002);
    chk({30'h0, rs}, {30'h0, cel_pkg::RESP_SLVERR}, "unmapped read");
    rchk(A_CTRL, 32'h0, "ctrl untouched");
    wstrb <= 4'hE;
    wr(A_CTRL, 32'h1F, OK);
    wstrb <= 4'hF;
    rchk(A_CTRL, 32'h0, "strobe off keeps ctrl");
    $display("reset and map done");
    for (int i = 0; i < 8; i++) begin
      raw <= rows[i].from_lvl;
      wr(A_CTRL, {27'h0, rows[i].ctrl}, OK);
      rchk(A_CTRL, {27'h0, rows[i].ctrl}, "ctrl readback");
      cyc(8);
      wr(A_STAT, 32'h1, OK);
      raw <= rows[i].to_lvl;
      cyc(8);
      rdr(A_STAT);
      chk(rd & 32'h1, {31'h0, rows[i].flag}, "edge flag");
      chk1(pwr_en, rows[i].ctrl[0], "power enable");
    end
    $display("edge table done");
    dbg <= 1'b1;
    wr(A_CTRL, 32'h19, OK);
    raw <= 1'b1;
    cyc(8);
    chk1(irq, 1'b0, "masked irq");
    wr(A_MASK, 32'h1, OK);
    chk1(irq, 1'b1, "irq");
    chk1(wake, 1'b0, "no wake in run");
    pmode <= cel_pkg::CEL_PWR_WAIT;
    cyc(2);
    chk1(wake, 1'b1, "wake from wait");
    wr(A_STAT, 32'h1, OK);
    chk1(irq, 1'b0, "irq cleared");
    pmode <= cel_pkg::CEL_PWR_SHALLOW;
    raw <= 1'b0;
    cyc(8);
    chk1(wake, 1'b1, "wake from stop");
    rchk(A_STAT, 32'h1, "flag in stop");
    wr(A_STAT, 32'h1, OK);
    cyc(8);
    rchk(A_STAT, 32'h0, "flag once");
    // Event pulse lands on the clearing write
    raw <= 1'b1;
    cyc(2);
    wr(A_STAT, 32'h1, OK);
    rchk(A_STAT, 32'h3, "set beats clear");
    raw <= 1'b0;
    cyc(8);
    wr(A_STAT, 32'h1, OK);
    dbg <= 1'b0;
    $display("interrupt and wake done");
    wr(A_CTRL, 32'h07, OK);
    raw <= 1'b1;
    cyc(8);
    chk1(res_pin, 1'b1, "pin high");
    chk1(res_pin_en, 1'b1, "pin enable");
    chk1(bg_sel, 1'b1, "bandgap");
    raw <= 1'b0;
    cyc(8);
    chk1(res_pin, 1'b0, "pin low");
    wr(A_CTRL, 32'h01, OK);
    cyc(2);
    chk1(res_pin_en, 1'b0, "pin off");
    chk1(bg_sel, 1'b0, "bandgap off");
    wr(A_CTRL, 32'h19, OK);
    raw <= 1'b1;
    cyc(8);
    aresetn <= 1'b0;
    cyc(6);
    aresetn <= 1'b1;
    pmode <= cel_pkg::CEL_PWR_RUN;
    raw <= 1'b0;
    rchk(A_CTRL, 32'h0, "ctrl after reset");
    rchk(A_MASK, 32'h0, "mask after reset");
    rchk(A_STAT, 32'h0, "status after reset");
    chk1(irq, 1'b0, "irq after reset");
    $display("pin and stop reset done");
    for (int m = 0; m < 2; m++) begin
      wr(A_CTRL, 32'h19, OK);
      wr(A_MASK, 32'h1, OK);
      cyc(8);
      raw <= 1'b1;
      cyc(8);
      pmode <= (m == 0) ? cel_pkg::CEL_PWR_DEEP_A : cel_pkg::CEL_PWR_DEEP_B;
      raw <= 1'b0;
      cyc(3);
      chk1(pwr_en, 1'b0, "powered down");
      chk1(irq, 1'b0, "no irq in deep");
      pmode <= cel_pkg::CEL_PWR_RUN;
      rchk(A_CTRL, 32'h0, "ctrl after deep");
      rchk(A_STAT, 32'h0, "status after deep");
      rchk(A_MASK, 32'h0, "mask after deep");
    end
    $display("deep stop done");
    report_and_stop();
  end
endmodule
`default_nettype wire
